/* File: src/btc_pkg.sv */
// constants and types for the bus termination, halt and reset controller
// Contract
// - suspend asserted stops processor while held
// - while suspended, float buses; arbitration continues
// - fault with suspend means retry, not trap
// - single step: one cycle per suspend release
// - fault during fault processing: stop, drive suspend
// - double fault leaves only by external reset
// - retry starts no fault processing; unlimited retries
// - fault during reset vector fetch is double
// - reset loads stack pointer, program counter, level
// - vector base variant clears base on reset
// - reset instruction drives reset 124 clocks
// - external reset ignored during reset instruction
// - acknowledge alone ends cycle normally
// - suspend with acknowledge: finish, stop, resume
// - fault without suspend ends cycle, trap
// - late fault traps only in late variant
// - fault plus suspend ends cycle, then retry
// - late fault plus suspend retries in variant
// - retry floats buses, reruns identical cycle
// - read-modify-write never retried, always traps
package btc_pkg;

  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;

  localparam logic [23:0] VEC_SSP_ADDR = 24'h00_0000;
  localparam logic [23:0] VEC_PC_ADDR  = 24'h00_0004;
  localparam logic [23:0] WORD_STEP    = 24'h00_0002;
  localparam logic [23:0] ZERO_ADDR    = 24'h00_0000;

  localparam logic [1:0] VEC_SP_LAST = 2'h1;
  localparam logic [1:0] VEC_PC_LAST = 2'h3;
  localparam logic [1:0] IDX_FIRST   = 2'h0;
  localparam logic [1:0] IDX_STEP    = 2'h1;

  // supervisor program space for vector fetches
  localparam logic [2:0] FC_SUP_PROG = 3'h6;
  localparam logic [2:0] IPL_RESET   = 3'h7;

  // reset instruction pulse length in clock periods (124)
  localparam logic [7:0] RST_INSTR_CYC = 8'h7c;
  localparam logic [7:0] CNT_LAST      = 8'h01;
  localparam logic [7:0] CNT_STEP      = 8'h01;

  // synchroniser bit positions
  localparam int SY_ACK = 0;
  localparam int SY_FLT = 1;
  localparam int SY_SUS = 2;
  localparam int SY_RST = 3;

  typedef enum logic [3:0] {
    S_RST,
    S_VEC,
    S_IDLE,
    S_BUS,
    S_LATE,
    S_END,
    S_HALT,
    S_RETRY,
    S_DBL,
    S_RSTI
  } btc_state_t;

  typedef enum logic [2:0] {
    ACT_WAIT,
    ACT_DONE,
    ACT_HALT,
    ACT_TRAP,
    ACT_RETRY
  } btc_act_t;

endpackage

/* File: src/btc_ctrl.sv */
// processor side bus cycle termination, halt and reset control
`timescale 1ns/10ps
module btc_ctrl #(
  parameter logic LATE_ERR = 1'b0,
  parameter logic HAS_VBR  = 1'b0
) (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        transfer_acknowledge_n,
  input  wire logic        bus_fault_input_n,
  input  wire logic        suspend_n_in,
  output logic             suspend_n_out,
  output logic             suspend_oe_n,
  input  wire logic        reset_n_in,
  output logic             reset_n_out,
  output logic             reset_oe_n,
  output logic             address_strobe_n,
  output logic             rd_wr_n,
  output logic [2:0]       fc_out,
  output logic [23:0]      addr_out,
  output logic             addr_oe_n,
  output logic [15:0]      data_out,
  input  wire logic [15:0] data_in,
  output logic             data_oe_n,
  input  wire logic        cyc_req,
  input  wire logic        cyc_write,
  input  wire logic        cyc_rmw,
  input  wire logic [2:0]  cyc_fc,
  input  wire logic [23:0] cyc_addr,
  input  wire logic [15:0] cyc_wdata,
  output logic             cyc_ready,
  output logic             cyc_done,
  output logic [15:0]      cyc_rdata,
  output logic             bus_err_trap,
  input  wire logic        instr_start,
  input  wire logic        rst_instr,
  output logic             rst_instr_done,
  output logic             halted,
  output logic             dbl_fault,
  output logic             sp_load,
  output logic [31:0]      sp_value,
  output logic             pc_load,
  output logic [31:0]      pc_value,
  output logic             ipl_load,
  output logic [2:0]       ipl_value,
  output logic             vbr_clear,
  output logic             core_run
);

  typedef struct packed {
    btc_pkg::btc_state_t st;
    logic [3:0]          sy1;
    logic [3:0]          sy2;
    logic [15:0]         dsy1;
    logic [15:0]         dsy2;
    logic [23:0]         addr;
    logic [15:0]         wdata;
    logic [2:0]          fc;
    logic                write;
    logic                rmw;
    logic [1:0]          idx;
    logic [7:0]          cnt;
    logic                exc;
    logic                boot;
    logic                halt_pend;
    logic [31:0]         sp;
    logic [31:0]         pc;
    logic [15:0]         rdata;
    logic                done;
    logic                trap;
    logic                sp_ld;
    logic                pc_ld;
    logic                ipl_ld;
    logic                vbr_clr;
    logic                rsti_done;
  } btc_regs_t;

  btc_regs_t r_reg;
  btc_regs_t r_next;

  logic ack;
  logic flt;
  logic sus;
  logic ext_rst;
  logic on_bus;

  // vector words arrive high half first
  function automatic logic [31:0] shift_in(
    input logic [31:0] prev,
    input logic [15:0] word
  );
    return {prev[15:0], word};
  endfunction

  // word address inside the two-entry reset vector table
  function automatic logic [23:0] vec_addr(input logic [1:0] idx);
    logic [23:0] base;
    logic [23:0] step;
    base = idx[1] ? btc_pkg::VEC_PC_ADDR : btc_pkg::VEC_SSP_ADDR;
    step = idx[0] ? btc_pkg::WORD_STEP : btc_pkg::ZERO_ADDR;
    return base + step;
  endfunction

  // states in which the core makes no progress on the bus
  function automatic logic is_stopped(input btc_pkg::btc_state_t s);
    return (s == btc_pkg::S_HALT) ||
           (s == btc_pkg::S_RETRY) ||
           (s == btc_pkg::S_DBL);
  endfunction

  // priority of cycle endings; rmw is checked first so it never retries
  function automatic btc_pkg::btc_act_t decide(
    input logic a,
    input logic f,
    input logic s,
    input logic m
  );
    btc_pkg::btc_act_t res;
    res = btc_pkg::ACT_WAIT;
    if (f && m) begin
      res = btc_pkg::ACT_TRAP;
    end else if (f && s) begin
      res = btc_pkg::ACT_RETRY;
    end else if (f) begin
      res = btc_pkg::ACT_TRAP;
    end else if (a && s) begin
      res = btc_pkg::ACT_HALT;
    end else if (a) begin
      res = btc_pkg::ACT_DONE;
    end
    return res;
  endfunction

  // only the second stage is read; inputs are evaluated two edges late
  assign ack = r_reg.sy2[btc_pkg::SY_ACK];
  assign flt = r_reg.sy2[btc_pkg::SY_FLT];
  assign sus = r_reg.sy2[btc_pkg::SY_SUS];
  // external reset counts only with suspend asserted alongside it
  assign ext_rst = r_reg.sy2[btc_pkg::SY_RST] && sus;

  assign on_bus = (r_reg.st == btc_pkg::S_BUS) ||
                  (r_reg.st == btc_pkg::S_LATE);

  always_comb begin
    btc_pkg::btc_act_t act;
    act = btc_pkg::ACT_WAIT;
    r_next = r_reg;
    r_next.sy1 = {~reset_n_in, ~suspend_n_in,
                  ~bus_fault_input_n, ~transfer_acknowledge_n};
    r_next.sy2 = r_reg.sy1;
    r_next.dsy1 = data_in;
    r_next.dsy2 = r_reg.dsy1;
    r_next.done = 1'b0;
    r_next.trap = 1'b0;
    r_next.sp_ld = 1'b0;
    r_next.pc_ld = 1'b0;
    r_next.ipl_ld = 1'b0;
    r_next.vbr_clr = 1'b0;
    r_next.rsti_done = 1'b0;
    if (instr_start) begin
      r_next.exc = 1'b0;
    end
    case (r_reg.st)
      btc_pkg::S_RST: begin
        // wait for the reset pin to clear before fetching vectors
        if (!r_reg.sy2[btc_pkg::SY_RST]) begin
          r_next.st = btc_pkg::S_VEC;
          r_next.boot = 1'b1;
          r_next.idx = btc_pkg::IDX_FIRST;
        end
      end
      btc_pkg::S_VEC: begin
        if (!sus) begin
          r_next.addr = vec_addr(r_reg.idx);
          r_next.write = 1'b0;
          r_next.rmw = 1'b0;
          r_next.fc = btc_pkg::FC_SUP_PROG;
          r_next.st = btc_pkg::S_BUS;
        end
      end
      btc_pkg::S_IDLE: begin
        if (rst_instr) begin
          r_next.st = btc_pkg::S_RSTI;
          r_next.cnt = btc_pkg::RST_INSTR_CYC;
        end else if (cyc_req && !sus) begin
          r_next.addr = cyc_addr;
          r_next.wdata = cyc_wdata;
          r_next.fc = cyc_fc;
          r_next.write = cyc_write;
          r_next.rmw = cyc_rmw;
          r_next.st = btc_pkg::S_BUS;
        end
      end
      btc_pkg::S_RSTI: begin
        // only the reset pin is driven; the counter counts down and no sp, pc or level loads
        if (r_reg.cnt == btc_pkg::CNT_LAST) begin
          r_next.st = btc_pkg::S_IDLE;
          r_next.rsti_done = 1'b1;
        end else begin
          r_next.cnt = r_reg.cnt - btc_pkg::CNT_STEP;
        end
      end
      btc_pkg::S_BUS: begin
        if (ack && !flt && LATE_ERR) begin
          r_next.st = btc_pkg::S_LATE;
        end else begin
          act = decide(ack, flt, sus, r_reg.rmw);
        end
      end
      btc_pkg::S_LATE: begin
        // one more sample after acknowledge catches the late fault
        act = decide(1'b1, flt, sus, r_reg.rmw);
      end
      btc_pkg::S_END: begin
        // stale acknowledge must clear before the next strobe
        if (!ack && !flt) begin
          if (r_reg.halt_pend) begin
            r_next.st = btc_pkg::S_HALT;
          end else if (r_reg.boot) begin
            r_next.st = btc_pkg::S_VEC;
          end else begin
            r_next.st = btc_pkg::S_IDLE;
          end
        end
      end
      btc_pkg::S_HALT: begin
        if (!sus) begin
          r_next.st = r_reg.boot ? btc_pkg::S_VEC : btc_pkg::S_IDLE;
        end
      end
      btc_pkg::S_RETRY: begin
        // same address, codes and data are still latched
        if (!sus && !flt && !ack) begin
          r_next.st = btc_pkg::S_BUS;
        end
      end
      btc_pkg::S_DBL: begin
        r_next.st = btc_pkg::S_DBL;
      end
      default: begin
        r_next.st = btc_pkg::S_RST;
      end
    endcase
    case (act)
      btc_pkg::ACT_DONE, btc_pkg::ACT_HALT: begin
        r_next.halt_pend = (act == btc_pkg::ACT_HALT);
        r_next.st = btc_pkg::S_END;
        if (r_reg.boot) begin
          if (!r_reg.idx[1]) begin
            r_next.sp = shift_in(r_reg.sp, r_reg.dsy2);
          end else begin
            r_next.pc = shift_in(r_reg.pc, r_reg.dsy2);
          end
          if (r_reg.idx == btc_pkg::VEC_SP_LAST) begin
            r_next.sp_ld = 1'b1;
          end
          if (r_reg.idx == btc_pkg::VEC_PC_LAST) begin
            r_next.pc_ld = 1'b1;
            r_next.ipl_ld = 1'b1;
            r_next.vbr_clr = HAS_VBR;
            r_next.boot = 1'b0;
          end
          r_next.idx = r_reg.idx + btc_pkg::IDX_STEP;
        end else begin
          r_next.done = 1'b1;
          r_next.rdata = r_reg.dsy2;
        end
      end
      btc_pkg::ACT_TRAP: begin
        // a fault before the next instruction, or while booting, is fatal
        if (r_reg.exc || r_reg.boot) begin
          r_next.st = btc_pkg::S_DBL;
        end else begin
          r_next.trap = 1'b1;
          r_next.exc = 1'b1;
          r_next.halt_pend = 1'b0;
          r_next.st = btc_pkg::S_END;
        end
      end
      btc_pkg::ACT_RETRY: begin
        // exc left alone so repeated retries never escalate
        r_next.st = btc_pkg::S_RETRY;
      end
      default: begin
      end
    endcase
    // the pin we drive ourselves cannot restart us mid pulse
    if (ext_rst && r_reg.st != btc_pkg::S_RSTI) begin
      r_next.st = btc_pkg::S_RST;
      r_next.exc = 1'b0;
      r_next.boot = 1'b0;
      r_next.halt_pend = 1'b0;
    end
  end

  // all state in one register; reset clears it to the wait state
  always_ff @(posedge clk) begin
    if (!nrst) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  // buses float outside an active cycle: halt, retry, reset, stop
  assign address_strobe_n = !on_bus;
  assign addr_oe_n = !on_bus;
  assign data_oe_n = !(on_bus && r_reg.write);
  assign addr_out = r_reg.addr;
  assign data_out = r_reg.wdata;
  assign fc_out = r_reg.fc;
  assign rd_wr_n = !r_reg.write;

  // open-drain lines: the data is always low, the enable decides
  assign suspend_n_out = 1'b0;
  assign suspend_oe_n = (r_reg.st != btc_pkg::S_DBL);
  assign reset_n_out = 1'b0;
  assign reset_oe_n = (r_reg.st != btc_pkg::S_RSTI);

  // ready drops on a synced reset so no request is taken into it
  assign cyc_ready = (r_reg.st == btc_pkg::S_IDLE) && !sus && !ext_rst;
  assign cyc_done = r_reg.done;
  assign cyc_rdata = r_reg.rdata;
  assign bus_err_trap = r_reg.trap;
  assign rst_instr_done = r_reg.rsti_done;
  assign halted = is_stopped(r_reg.st);
  assign dbl_fault = (r_reg.st == btc_pkg::S_DBL);
  assign sp_load = r_reg.sp_ld;
  assign sp_value = r_reg.sp;
  assign pc_load = r_reg.pc_ld;
  assign pc_value = r_reg.pc;
  assign ipl_load = r_reg.ipl_ld;
  assign ipl_value = btc_pkg::IPL_RESET;
  assign vbr_clear = r_reg.vbr_clr;
  assign core_run = !r_reg.boot &&
                    (r_reg.st != btc_pkg::S_RST) &&
                    (r_reg.st != btc_pkg::S_DBL);

endmodule

/* File: verif/btc_bus_model.sv */
// far-side bus logic: acknowledges, faults or retries each strobe
`timescale 1ns/10ps
module btc_bus_model (
  input  wire logic        clk,
  input  wire logic        address_strobe_n,
  input  wire logic [23:0] addr_out,
  input  wire logic [1:0]  mode,
  output logic             ack_n,
  output logic             flt_n,
  output logic             sus_n,
  output logic [15:0]      rdata
);
  logic [2:0] dly;
  logic [2:0] hold = 3'h0;
  // released lines read inverted so stale data never matches
  assign rdata = (addr_out[15:0] ^ 16'h5a5a) ^ {16{address_strobe_n}};
  assign sus_n = (hold == 3'h0);
  always_ff @(posedge clk) begin
    if (address_strobe_n) begin
      ack_n <= 1'b1;
      flt_n <= 1'b1;
      dly   <= 3'h0;
      hold  <= hold - {2'h0, hold != 3'h0};
    end else begin
      dly <= dly + {2'h0, dly != 3'h7};
      if (dly == 3'h2) begin
        ack_n <= (mode != 2'h0);
        flt_n <= (mode == 2'h0);
        // suspend outlives the fault by the countdown
        hold  <= (mode == 2'h2) ? 3'h6 : 3'h0;
      end
    end
  end
endmodule

/* File: verif/btc_ctrl_checker.sv */
// concurrent checks on the controller's pins
`timescale 1ns/10ps
module btc_ctrl_checker #(
  parameter logic HAS_VBR = 1'b0
) (
  input wire logic       clk,
  input wire logic       nrst,
  input wire logic       transfer_acknowledge_n,
  input wire logic       bus_fault_input_n,
  input wire logic       suspend_n_in,
  input wire logic       suspend_oe_n,
  input wire logic       reset_n_in,
  input wire logic       reset_oe_n,
  input wire logic       address_strobe_n,
  input wire logic       addr_oe_n,
  input wire logic       data_oe_n,
  input wire logic       cyc_done,
  input wire logic       bus_err_trap,
  input wire logic       dbl_fault,
  input wire logic       sp_load,
  input wire logic       pc_load,
  input wire logic       ipl_load,
  input wire logic [2:0] ipl_value,
  input wire logic       vbr_clear
);
  logic [7:0] low_cnt;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // saturates so a stuck pin cannot wrap back to a legal count
  always_ff @(posedge clk) begin
    if (!nrst || reset_oe_n) begin
      low_cnt <= 8'h00;
    end else if (low_cnt != 8'hff) begin
      low_cnt <= low_cnt + 8'h01;
    end
  end
  float_bus_a: assert property (
    address_strobe_n |-> addr_oe_n && data_oe_n)
    else $error("buses driven with strobe negated");
  halt_hold_a: assert property (
    (!suspend_n_in && address_strobe_n)[*4] |=> address_strobe_n)
    else $error("cycle started while suspended");
  susp_drive_a: assert property (
    dbl_fault == !suspend_oe_n)
    else $error("suspend drive differs from double fault");
  dbl_hold_a: assert property (
    dbl_fault && reset_n_in && $past(reset_n_in) && $past(reset_n_in, 2)
      && $past(reset_n_in, 3) |=> dbl_fault)
    else $error("double fault left without reset");
  rst_pulse_a: assert property (
    $rose(reset_oe_n) |-> low_cnt == 8'h7c)
    else $error("reset pulse length wrong");
  rst_keep_a: assert property (
    !reset_oe_n |-> !sp_load && !pc_load && !ipl_load)
    else $error("registers loaded during reset pulse");
  vec_load_a: assert property (
    pc_load |-> ipl_load && ipl_value == 3'h7 && vbr_clear == HAS_VBR)
    else $error("vector load incomplete");
  trap_cause_a: assert property (
    bus_err_trap |-> !$past(bus_fault_input_n, 2))
    else $error("trap without fault");
  done_cause_a: assert property (
    cyc_done |-> !$past(transfer_acknowledge_n, 2)
      && $past(bus_fault_input_n, 2))
    else $error("done without clean acknowledge");
  cover property (bus_err_trap);
  cover property ($rose(dbl_fault));
  cover property ($rose(reset_oe_n));
endmodule

/* File: verif/btc_ctrl_tb.sv */
// self-checking bench for the termination, halt and reset controller
`timescale 1ns/10ps
module btc_ctrl_tb;
  localparam int F_RDY = 0, F_DBL = 1, F_HLT = 2, F_TRP = 3;
  localparam int F_DONE = 4, F_SP = 5, F_PC = 6, F_STB = 7;
  logic        clk, nrst = 1'b0, tb_rst_n = 1'b0, tb_sus_n = 1'b0;
  logic        cyc_req = 1'b0, cyc_write = 1'b0, cyc_rmw = 1'b0;
  logic        instr_start = 1'b0, rst_instr = 1'b0, ok;
  logic [1:0]  mode = 2'h0;
  logic [2:0]  cyc_fc = 3'h5;
  logic [23:0] cyc_addr = 24'h00_0000;
  logic [15:0] cyc_wdata = 16'h0000;
  logic        ack_n, flt_n, m_sus_n, sus_w, rst_w;
  logic        suspend_n_out, suspend_oe_n, reset_n_out, reset_oe_n;
  logic        address_strobe_n, rd_wr_n, addr_oe_n, data_oe_n;
  logic        cyc_ready, cyc_done, bus_err_trap, rst_instr_done;
  logic        halted, dbl_fault, sp_load, pc_load, ipl_load;
  logic        vbr_clear, core_run;
  logic [2:0]  fc_out, ipl_value;
  logic [23:0] addr_out;
  logic [15:0] data_out, data_in, cyc_rdata;
  logic [31:0] sp_value, pc_value;
  logic [7:0]  fl;
  int          checked, miscompares, cycles, traps, lowcnt, spcnt, rdn;
  // wired-and of every party on the shared open-drain lines
  assign sus_w = tb_sus_n & m_sus_n & (suspend_oe_n | suspend_n_out);
  assign rst_w = tb_rst_n & (reset_oe_n | reset_n_out);
  assign fl = {~address_strobe_n, pc_load, sp_load, cyc_done,
               bus_err_trap, halted, dbl_fault, cyc_ready};
  btc_ctrl #(.LATE_ERR(1'b0), .HAS_VBR(1'b1)) u_dut (
    .clk, .nrst, .transfer_acknowledge_n(ack_n),
    .bus_fault_input_n(flt_n), .suspend_n_in(sus_w), .suspend_n_out,
    .suspend_oe_n, .reset_n_in(rst_w), .reset_n_out, .reset_oe_n,
    .address_strobe_n, .rd_wr_n, .fc_out, .addr_out, .addr_oe_n,
    .data_out, .data_in, .data_oe_n, .cyc_req, .cyc_write, .cyc_rmw,
    .cyc_fc, .cyc_addr, .cyc_wdata, .cyc_ready, .cyc_done, .cyc_rdata,
    .bus_err_trap, .instr_start, .rst_instr, .rst_instr_done, .halted,
    .dbl_fault, .sp_load, .sp_value, .pc_load, .pc_value, .ipl_load,
    .ipl_value, .vbr_clear, .core_run);
  btc_bus_model u_bus (.clk, .address_strobe_n, .addr_out, .mode,
    .ack_n, .flt_n, .sus_n(m_sus_n), .rdata(data_in));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(negedge clk) begin
    if (bus_err_trap === 1'b1) traps++;
    if (reset_oe_n === 1'b0) lowcnt++;
    if (sp_load === 1'b1) spcnt++;
    if (rst_instr_done === 1'b1) rdn++;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      miscompares++;
      summarize();
    end
  end
  function automatic logic [15:0] rd(input logic [23:0] a);
    return a[15:0] ^ 16'h5a5a;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic till(input int b, output logic seen);
    seen = 1'b0;
    for (int i = 0; i < 400 && !seen; i++) begin
      @(negedge clk);
      seen = (fl[b] === 1'b1);
    end
  endtask
  task automatic req(input logic [23:0] a, input logic wr, input logic rmw);
    till(F_RDY, ok);
    @(posedge clk);
    cyc_req <= 1'b1;
    cyc_addr <= a;
    cyc_write <= wr;
    cyc_rmw <= rmw;
    cyc_wdata <= ~a[15:0];
    @(posedge clk);
    cyc_req <= 1'b0;
  endtask
  task automatic pulse_start();
    @(posedge clk) instr_start <= 1'b1;
    @(posedge clk) instr_start <= 1'b0;
  endtask
  task automatic pin_rst();
    @(posedge clk);
    tb_rst_n <= 1'b0;
    tb_sus_n <= 1'b0;
    repeat (12) @(posedge clk);
    tb_rst_n <= 1'b1;
    tb_sus_n <= 1'b1;
  endtask
  task automatic t_boot();
    pin_rst();
    till(F_SP, ok);
    chk(sp_value, {rd(24'h00_0000), rd(24'h00_0002)});
    till(F_PC, ok);
    chk(pc_value, {rd(24'h00_0004), rd(24'h00_0006)});
    chk({ipl_load, ipl_value, vbr_clear}, 5'h1f);
  endtask
  task automatic t_read();
    for (int w = 0; w < 2; w++) begin
      req(24'h00_1234 + w, w[0], 1'b0);
      till(F_DONE, ok);
      chk(ok, 1'b1);
      if (w == 0) chk(cyc_rdata, rd(24'h00_1234));
    end
  endtask
  task automatic t_trap();
    for (int r = 0; r < 2; r++) begin
      mode <= r[0] ? 2'h2 : 2'h1;
      req(24'h00_0100, 1'b0, r[0]);
      till(F_TRP, ok);
      chk(ok, 1'b1);
      pulse_start();
    end
    mode <= 2'h0;
  endtask
  task automatic t_retry();
    int t0;
    t0 = traps;
    mode <= 2'h2;
    req(24'h00_0abc, 1'b1, 1'b0);
    for (int k = 0; k < 2; k++) begin
      till(F_HLT, ok);
      chk(ok, 1'b1);
      till(F_STB, ok);
      chk({addr_out, data_out}, {24'h00_0abc, 16'hf543});
      chk({fc_out, rd_wr_n, data_oe_n}, 5'h14);
    end
    @(posedge clk) mode <= 2'h0;
    till(F_DONE, ok);
    chk(ok, 1'b1);
    chk(traps, t0);
  endtask
  task automatic t_halt();
    for (int k = 0; k < 2; k++) begin
      req(24'h00_0200 + k, 1'b0, 1'b0);
      tb_sus_n <= 1'b0;
      till(F_DONE, ok);
      chk(ok, 1'b1);
      till(F_HLT, ok);
      repeat (20) @(negedge clk);
      chk({halted, cyc_ready, address_strobe_n}, 3'h5);
      @(posedge clk) tb_sus_n <= 1'b1;
    end
  endtask
  task automatic t_rsti();
    till(F_RDY, ok);
    lowcnt = 0;
    spcnt = 0;
    rdn = 0;
    @(posedge clk) rst_instr <= 1'b1;
    @(posedge clk) rst_instr <= 1'b0;
    repeat (10) @(posedge clk);
    pin_rst();
    repeat (150) @(posedge clk);
    chk(lowcnt, 124);
    chk(spcnt, 0);
    chk(core_run, 1'b1);
    chk(rdn, 1);
  endtask
  task automatic t_dbl();
    mode <= 2'h1;
    req(24'h00_0300, 1'b0, 1'b0);
    till(F_TRP, ok);
    req(24'h00_0302, 1'b0, 1'b0);
    till(F_DBL, ok);
    chk({ok, sus_w}, 2'h2);
    pulse_start();
    repeat (30) @(negedge clk);
    chk(dbl_fault, 1'b1);
    pin_rst();
    till(F_DBL, ok);
    chk(ok, 1'b1);
    mode <= 2'h0;
    pin_rst();
    till(F_PC, ok);
    chk({ok, dbl_fault}, 2'h2);
  endtask
  initial begin
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    t_boot();
    t_read();
    t_trap();
    t_retry();
    t_halt();
    t_rsti();
    t_dbl();
    summarize();
  end
endmodule
bind btc_ctrl btc_ctrl_checker #(.HAS_VBR(HAS_VBR)) u_chk (
  .clk, .nrst, .transfer_acknowledge_n, .bus_fault_input_n,
  .suspend_n_in, .suspend_oe_n, .reset_n_in, .reset_oe_n,
  .address_strobe_n, .addr_oe_n, .data_oe_n, .cyc_done, .bus_err_trap,
  .dbl_fault, .sp_load, .pc_load, .ipl_load, .ipl_value, .vbr_clear);
